// >>> rtl/ivp_pkg.sv
// Constants, register map and carrier types of the interrupt prioritizer
package ivp_pkg;

  // Source counts
  localparam int NUM_MASKABLE = 24;
  localparam int NUM_PINS     = 7;
  localparam int NUM_KEYS     = 8;
  localparam int NUM_PERIPH   = 15;
  localparam int NUM_SOURCES  = 26;

  // Default priority numbers of the maskable sources
  localparam logic [4:0] IDX_WATCHDOG = 5'h00;
  localparam logic [4:0] IDX_PIN0     = 5'h01;
  localparam logic [4:0] IDX_KEY      = 5'h08;
  localparam logic [4:0] IDX_PERIPH0  = 5'h09;
  localparam logic [4:0] IDX_TWO_WIRE = 5'h0E;

  // Variant without the two-wire serial interface clears this
  localparam logic TWO_WIRE_PRESENT = 1'b1;

  // Vector table addresses
  localparam logic [15:0] VEC_NMI       = 16'h0004;
  localparam logic [15:0] VEC_MASK_BASE = 16'h0004;
  localparam logic [15:0] VEC_BRK       = 16'h003E;

  // Register indices on the plain register port
  localparam logic [3:0] REG_FLAG = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h1;
  localparam logic [3:0] REG_PRIO = 4'h2;
  localparam logic [3:0] REG_EDGE = 4'h3;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h5;

  // Field positions
  localparam int EDGE_RISE_LSB     = 0;
  localparam int EDGE_FALL_LSB     = 8;
  localparam int CTRL_WDT_INTERVAL = 0;
  localparam int CTRL_CAPA_CAPTURE = 1;

  // Values after reset
  localparam logic [23:0] RST_FLAG = 24'h00_0000;
  localparam logic [23:0] RST_MASK = 24'hFF_FFFF;
  localparam logic [23:0] RST_PRIO = 24'hFF_FFFF;
  localparam logic [6:0]  RST_EDGE = 7'h00;
  localparam logic [1:0]  RST_CTRL = 2'h0;

  // Kind of the source currently offered to the core
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_NMI  = 2'b01,
    SEL_SW   = 2'b10,
    SEL_MASK = 2'b11
  } ivp_sel_type;

  // Internal peripheral event pulses, first field is the highest priority
  typedef struct packed {
    logic async_rx_error_irq;
    logic async_rx_done_irq;
    logic async_tx_done_irq;
    logic clocked_serial_a_irq;
    logic clocked_serial_b_irq;
    logic two_wire_done_irq;
    logic watch_interval_irq;
    logic capcmp_a_match;
    logic capcmp_a_edge;
    logic capcmp_timer_irq_b;
    logic timer_a_match_irq;
    logic timer_b_match_irq;
    logic eight_bit_timer_irq_0;
    logic eight_bit_timer_irq_1;
    logic adc_done_irq;
    logic watch_overflow_irq;
  } ivp_periph_type;

endpackage

// >>> rtl/ivp_edge_detect.sv
// Per-bit rising and falling edge detector with enable masks
module ivp_edge_detect
  import ivp_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Levels and enables
  input  wire logic [W-1:0] level,
  input  wire logic [W-1:0] rise_en,
  input  wire logic [W-1:0] fall_en,
  // One-cycle edge pulses
  output logic      [W-1:0] edge_pulse
);

  logic [W-1:0] prev_ff;

  // First sample after reset sees a low history, so a pin that is high
  // at reset gives one rising pulse if rising detection is enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_ff <= '0;
    end else if (ce) begin
      prev_ff <= level;
    end
  end

  assign edge_pulse = {W{ce}} & ((level & ~prev_ff & rise_en) |
                                 (~level & prev_ff & fall_en));

endmodule

// >>> rtl/ivp_prioritizer.sv
// Vectored interrupt prioritizer: flags, masks, groups, arbitration
//
// Function
// - Non-maskable request is accepted even with interrupts disabled.
// - Non-maskable request skips group control and beats every request.
// - New non-maskable request waits while one is in service.
// - Non-maskable request raises standby release, leaving halt.
// - Only watchdog overflow is non-maskable; its vector is 0004H.
// - Maskable sources are masked and grouped high or low by flag.
// - Unmasked high-group request nests over a low-group handler.
// - Equal-group ties resolve by fixed order, 0 highest, 23 lowest.
// - Maskable request raises standby release, leaving stop and halt.
// - Eight external and sixteen internal maskable request inputs.
// - Break instruction raises software interrupt with vector 003EH.
// - Software interrupt ignores global disable and group arbitration.
// - Twenty-six sources: non-maskable, maskable and software together.
// - Watchdog in interval mode is maskable source with priority 0.
// - Seven pin-edge sources, priorities 1 to 7, vectors 0006H-0012H.
// - Key return on port 4 falling edge, priority 8, vector 0014H.
// - Peripheral sources priorities 9 to 23, vectors 0016H to 0032H.
// - First timer source: match in compare use, edge in capture use.
// - Without two-wire interface, vector 0020H source is absent.
// - Acknowledge clears the source's request flag automatically.
// - Each maskable source has a mask flag; reset masks all.
//
// The register addresses and the plain strobed port were decided locally.
module ivp_prioritizer
  import ivp_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  // Register port
  input  wire logic [3:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  // Interrupt sources
  input  wire logic                    watchdog_irq,
  input  wire logic [NUM_PINS-1:0]     ext_pin,
  input  wire logic [NUM_KEYS-1:0]     key_port,
  input  wire ivp_periph_type          periph,
  input  wire logic                    break_instruction,
  // Processor core side
  input  wire logic                    int_enable,
  input  wire logic                    core_ack,
  input  wire logic                    svc_return,
  output logic                         irq_req,
  output logic      [15:0]             irq_vector,
  output logic                         standby_release_halt,
  output logic                         standby_release_stop
);

  // State
  logic [23:0]  flag_ff, mask_ff, prio_ff;
  logic [6:0]   rise_en_ff, fall_en_ff;
  logic [1:0]   ctrl_ff;
  logic         nmi_pend_ff, sw_pend_ff;
  logic         nmi_isr_ff, high_isr_ff, low_isr_ff;
  logic         irq_req_ff, sel_high_ff;
  ivp_sel_type  sel_kind_ff;
  logic [4:0]   sel_idx_ff;
  logic [15:0]  irq_vector_ff;
  logic         rel_halt_ff, rel_stop_ff;
  logic [31:0]  reg_rdata_ff;
  logic [23:0]  nxt_flag;

  // Event sources
  logic [NUM_PINS-1:0] pin_pulse;
  logic [NUM_KEYS-1:0] key_pulse;
  logic [15:0]         periph_bits;
  logic                capcmp_a_event;
  logic [23:0]         ev;
  logic                wdt_interval;

  assign wdt_interval = ctrl_ff[CTRL_WDT_INTERVAL];
  assign periph_bits  = periph;

  ivp_edge_detect #(.W(NUM_PINS)) u_pin_edge (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .level      (ext_pin),
    .rise_en    (rise_en_ff),
    .fall_en    (fall_en_ff),
    .edge_pulse (pin_pulse)
  );

  ivp_edge_detect #(.W(NUM_KEYS)) u_key_edge (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .level      (key_port),
    .rise_en    ({NUM_KEYS{1'b0}}),
    .fall_en    ({NUM_KEYS{1'b1}}),
    .edge_pulse (key_pulse)
  );

  // Capture use takes the input edge, compare use the counter match
  assign capcmp_a_event = ctrl_ff[CTRL_CAPA_CAPTURE] ?
                          periph.capcmp_a_edge :
                          periph.capcmp_a_match;

  // Priority order 0..23 of the 24 maskable inputs
  assign ev[0]    = watchdog_irq & wdt_interval;
  assign ev[7:1]  = pin_pulse;
  assign ev[8]    = |key_pulse;
  // Struct is MSB first, so the bit order is reversed on the way in
  genvar pk;
  generate
    for (pk = 0; pk < 7; pk++) begin : g_periph
      assign ev[9 + pk]  = periph_bits[15 - pk];
      assign ev[17 + pk] = periph_bits[6 - pk];
    end
  endgenerate
  assign ev[16]   = capcmp_a_event;

  // Register decode
  logic wr_flag, wr_mask, wr_prio, wr_edge, wr_ctrl;
  assign wr_flag = reg_wr & (reg_addr == REG_FLAG);
  assign wr_mask = reg_wr & (reg_addr == REG_MASK);
  assign wr_prio = reg_wr & (reg_addr == REG_PRIO);
  assign wr_edge = reg_wr & (reg_addr == REG_EDGE);
  assign wr_ctrl = reg_wr & (reg_addr == REG_CTRL);

  // Arbitration
  logic [23:0] req_hi, req_lo;
  logic [4:0]  hi_idx, lo_idx;
  logic        nmi_ok, sw_ok, hi_ok, lo_ok, cand_valid;
  ivp_sel_type cand_kind;
  logic [4:0]  cand_idx;
  logic [15:0] cand_vec;
  logic        ack_take;

  function automatic logic [4:0] first_set(input logic [23:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int k = NUM_MASKABLE - 1; k >= 0; k--) begin
      if (v[k]) begin
        idx = 5'(k);
      end
    end
    return idx;
  endfunction

  assign req_hi = flag_ff & ~mask_ff & ~prio_ff;
  assign req_lo = flag_ff & ~mask_ff & prio_ff;
  assign hi_idx = first_set(req_hi);
  assign lo_idx = first_set(req_lo);
  assign nmi_ok = nmi_pend_ff & ~nmi_isr_ff;
  assign sw_ok  = sw_pend_ff;
  assign hi_ok  = int_enable & (|req_hi) & ~high_isr_ff;
  assign lo_ok  = int_enable & (|req_lo) & ~high_isr_ff & ~low_isr_ff;
  assign cand_valid = nmi_ok | sw_ok | hi_ok | lo_ok;
  assign cand_kind  = nmi_ok ? SEL_NMI :
                      sw_ok  ? SEL_SW  :
                      (hi_ok | lo_ok) ? SEL_MASK : SEL_NONE;
  assign cand_idx   = hi_ok ? hi_idx : lo_idx;
  assign ack_take   = ce & core_ack & irq_req_ff;

  always_comb begin
    case (cand_kind)
      SEL_NMI:  cand_vec = VEC_NMI;
      SEL_SW:   cand_vec = VEC_BRK;
      SEL_MASK: cand_vec = 16'(VEC_MASK_BASE + {cand_idx, 1'b0});
      default:  cand_vec = 16'h0000;
    endcase
  end

  // Request flags: a new event beats acknowledge and software clears
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MASKABLE; gi++) begin : g_flag
      logic ack_clr;
      assign ack_clr = ack_take & (sel_kind_ff == SEL_MASK) &
                       (sel_idx_ff == 5'(gi));
      if (gi == int'(IDX_TWO_WIRE) && !TWO_WIRE_PRESENT) begin : g_absent
        assign nxt_flag[gi] = 1'b0;
      end else begin : g_present
        assign nxt_flag[gi] = ev[gi] |
                              (wr_flag ? reg_wdata[gi] :
                               (flag_ff[gi] & ~ack_clr));
      end
    end
  endgenerate

  // Register file
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_ff    <= RST_FLAG;
      mask_ff    <= RST_MASK;
      prio_ff    <= RST_PRIO;
      rise_en_ff <= RST_EDGE;
      fall_en_ff <= RST_EDGE;
      ctrl_ff    <= RST_CTRL;
    end else if (ce) begin
      flag_ff <= nxt_flag;
      if (wr_mask) begin
        mask_ff <= reg_wdata[23:0];
      end
      if (wr_prio) begin
        prio_ff <= reg_wdata[23:0];
      end
      if (wr_edge) begin
        rise_en_ff <= reg_wdata[EDGE_RISE_LSB +: NUM_PINS];
        fall_en_ff <= reg_wdata[EDGE_FALL_LSB +: NUM_PINS];
      end
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata[1:0];
      end
    end
  end

  // Non-maskable and software pending; a fresh event beats the ack clear
  logic nxt_nmi_pend, nxt_sw_pend;
  assign nxt_nmi_pend = (watchdog_irq & ~wdt_interval) |
                        (nmi_pend_ff &
                         ~(ack_take & (sel_kind_ff == SEL_NMI)));
  assign nxt_sw_pend  = break_instruction |
                        (sw_pend_ff &
                         ~(ack_take & (sel_kind_ff == SEL_SW)));

  // In-service levels; a return closes the highest one: non-maskable, then high, then low
  logic nxt_nmi_isr, nxt_high_isr, nxt_low_isr;
  logic ret_nmi, ret_high, ret_low;
  assign ret_nmi  = svc_return & nmi_isr_ff;
  assign ret_high = svc_return & ~nmi_isr_ff & high_isr_ff;
  assign ret_low  = svc_return & ~nmi_isr_ff & ~high_isr_ff & low_isr_ff;
  assign nxt_nmi_isr  = (nmi_isr_ff & ~ret_nmi) |
                        (ack_take & (sel_kind_ff == SEL_NMI));
  assign nxt_high_isr = (high_isr_ff & ~ret_high) |
                        (ack_take & (sel_kind_ff == SEL_MASK) &
                         sel_high_ff);
  assign nxt_low_isr  = (low_isr_ff & ~ret_low) |
                        (ack_take & (sel_kind_ff == SEL_MASK) &
                         ~sel_high_ff);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nmi_pend_ff <= 1'b0;
      sw_pend_ff  <= 1'b0;
      nmi_isr_ff  <= 1'b0;
      high_isr_ff <= 1'b0;
      low_isr_ff  <= 1'b0;
    end else if (ce) begin
      nmi_pend_ff <= nxt_nmi_pend;
      sw_pend_ff  <= nxt_sw_pend;
      nmi_isr_ff  <= nxt_nmi_isr;
      high_isr_ff <= nxt_high_isr;
      low_isr_ff  <= nxt_low_isr;
    end
  end

  // Offer to the core; dropped for one cycle after an ack so that the
  // stale winner is never offered twice
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_req_ff    <= 1'b0;
      sel_kind_ff   <= SEL_NONE;
      sel_idx_ff    <= 5'h00;
      sel_high_ff   <= 1'b0;
      irq_vector_ff <= 16'h0000;
    end else if (ce) begin
      if (ack_take) begin
        irq_req_ff <= 1'b0;
      end else begin
        irq_req_ff    <= cand_valid;
        sel_kind_ff   <= cand_kind;
        sel_idx_ff    <= cand_idx;
        sel_high_ff   <= hi_ok;
        irq_vector_ff <= cand_vec;
      end
    end
  end

  // Standby release does not depend on global enable or in-service state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rel_halt_ff <= 1'b0;
      rel_stop_ff <= 1'b0;
    end else if (ce) begin
      rel_halt_ff <= nmi_pend_ff | (|(flag_ff & ~mask_ff));
      rel_stop_ff <= |(flag_ff & ~mask_ff);
    end
  end

  // Read path; data stand only in the cycle after the strobe
  logic [31:0] rd_mux, stat_word;
  assign stat_word = {26'h000_0000, sw_pend_ff, nmi_pend_ff, low_isr_ff,
                      high_isr_ff, nmi_isr_ff, irq_req_ff};
  assign rd_mux =
    (reg_addr == REG_FLAG) ? {8'h00, flag_ff} :
    (reg_addr == REG_MASK) ? {8'h00, mask_ff} :
    (reg_addr == REG_PRIO) ? {8'h00, prio_ff} :
    (reg_addr == REG_EDGE) ? {17'h0_0000, fall_en_ff, 1'b0, rise_en_ff} :
    (reg_addr == REG_CTRL) ? {30'h0000_0000, ctrl_ff} :
    (reg_addr == REG_STAT) ? stat_word : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata            = reg_rdata_ff;
  assign irq_req              = irq_req_ff;
  assign irq_vector           = irq_vector_ff;
  assign standby_release_halt = rel_halt_ff;
  assign standby_release_stop = rel_stop_ff;

  // Checks
  a_nmi_ignores_ie: assert property (@(posedge clk) disable iff (rst)
    ce & ~core_ack & nmi_ok & ~int_enable |=>
      irq_req_ff && irq_vector_ff == VEC_NMI)
    else $error("nmi not offered while disabled");
  a_nmi_wins_all: assert property (@(posedge clk) disable iff (rst)
    ce & ~ack_take & nmi_ok & (sw_ok | hi_ok | lo_ok) |=>
      sel_kind_ff == SEL_NMI)
    else $error("nmi lost arbitration");
  a_nmi_held_pend: assert property (@(posedge clk) disable iff (rst)
    nmi_isr_ff & irq_req_ff |-> sel_kind_ff != SEL_NMI)
    else $error("nested nmi offered");
  a_halt_release: assert property (@(posedge clk) disable iff (rst)
    ce & nmi_pend_ff |=> standby_release_halt)
    else $error("nmi gave no halt release");
  a_mask_gate: assert property (@(posedge clk) disable iff (rst)
    ce & ~ack_take & ((flag_ff & ~mask_ff) == 24'h00_0000) &
      ~nmi_ok & ~sw_ok |=> ~irq_req_ff)
    else $error("masked source offered");
  a_high_nests: assert property (@(posedge clk) disable iff (rst)
    ce & ~ack_take & low_isr_ff & ~high_isr_ff & int_enable &
      (|req_hi) & ~nmi_ok & ~sw_ok |=>
      irq_req_ff && sel_kind_ff == SEL_MASK && sel_high_ff)
    else $error("high group blocked by low handler");
  a_fixed_order: assert property (@(posedge clk) disable iff (rst)
    ce & ~ack_take & hi_ok & ~nmi_ok & ~sw_ok |=>
      sel_idx_ff == $past(hi_idx))
    else $error("wrong default priority");
  a_stop_release: assert property (@(posedge clk) disable iff (rst)
    ce & (|(flag_ff & ~mask_ff)) |=> standby_release_stop ##0
      standby_release_halt)
    else $error("maskable gave no standby release");
  a_brk_vector: assert property (@(posedge clk) disable iff (rst)
    ce & ~ack_take & sw_ok & ~nmi_ok |=>
      irq_req_ff && irq_vector_ff == VEC_BRK)
    else $error("break not offered");
  a_ack_clears: assert property (@(posedge clk) disable iff (rst)
    ack_take & (sel_kind_ff == SEL_MASK) & ~ev[sel_idx_ff] & ~wr_flag |=>
      ~flag_ff[$past(sel_idx_ff)] ##1 1'b1)
    else $error("flag kept after ack");
  a_vector_map: assert property (@(posedge clk) disable iff (rst)
    irq_req_ff & (sel_kind_ff == SEL_MASK) |->
      irq_vector_ff == 16'(VEC_MASK_BASE + {sel_idx_ff, 1'b0}))
    else $error("vector does not match source");

  c_nmi_ack: cover property (@(posedge clk) disable iff (rst)
    ack_take & (sel_kind_ff == SEL_NMI));
  c_nest: cover property (@(posedge clk) disable iff (rst)
    ack_take & low_isr_ff & sel_high_ff);
  c_brk_ack: cover property (@(posedge clk) disable iff (rst)
    ack_take & (sel_kind_ff == SEL_SW));
  c_tie: cover property (@(posedge clk) disable iff (rst)
    ce & hi_ok & ($countones(req_hi) > 1));

endmodule

// >>> sim/ivp_core_model.sv
// Behavioural processor core that acknowledges offered interrupts
module ivp_core_model
  import ivp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Acknowledge behaviour
  input  wire logic        ack_en,
  input  wire logic [3:0]  ack_delay,
  // Prioritizer side
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  output logic             core_ack,
  // Record of the last taken interrupt
  output logic [15:0]      taken_vec,
  output logic [7:0]       taken_cnt
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0]  wait_ff;
  logic        ack_ff;
  logic [15:0] vec_ff;
  logic [7:0]  cnt_ff;

  assign core_ack  = ack_ff;
  assign taken_vec = vec_ff;
  assign taken_cnt = cnt_ff;

  // Vector is latched at the edge that takes the ack, since the offer
  // may still change to a higher request while the ack is being raised
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_ff <= 4'h0;
      ack_ff  <= 1'b0;
      vec_ff  <= 16'h0000;
      cnt_ff  <= 8'h00;
    end else if (ack_ff) begin
      ack_ff  <= 1'b0;
      wait_ff <= 4'h0;
      vec_ff  <= irq_vector;
      cnt_ff  <= cnt_ff + 8'h01;
    end else if (irq_req && ack_en) begin
      if (wait_ff == ack_delay) begin
        ack_ff <= 1'b1;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end else begin
      wait_ff <= 4'h0;
    end
  end
endmodule

// >>> sim/tb_vectored_interrupt_prioritizer.sv
// Self-checking bench of the interrupt prioritizer with a core model
module tb_vectored_interrupt_prioritizer;
  import ivp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic           clk;
  logic           rst;
  logic [3:0]     reg_addr;
  logic [31:0]    reg_wdata;
  logic           reg_wr;
  logic           reg_rd;
  logic [31:0]    reg_rdata;
  logic           watchdog_irq;
  logic [6:0]     ext_pin;
  logic [7:0]     key_port;
  ivp_periph_type periph;
  ivp_periph_type pv;
  logic           break_instruction;
  logic           int_enable;
  logic           core_ack;
  logic           svc_return;
  logic           irq_req;
  logic [15:0]    irq_vector;
  logic           standby_release_halt;
  logic           standby_release_stop;
  logic           ack_en;
  logic [3:0]     ack_delay;
  logic [15:0]    taken_vec;
  logic [7:0]     taken_cnt;
  logic [31:0]    d;
  int             miscompares;
  int             check_count;

  ivp_prioritizer dut (
    .clk(clk), .rst(rst), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .watchdog_irq(watchdog_irq), .ext_pin(ext_pin), .key_port(key_port),
    .periph(periph), .break_instruction(break_instruction),
    .int_enable(int_enable), .core_ack(core_ack), .svc_return(svc_return),
    .irq_req(irq_req), .irq_vector(irq_vector),
    .standby_release_halt(standby_release_halt),
    .standby_release_stop(standby_release_stop)
  );

  ivp_core_model core (
    .clk(clk), .rst(rst), .ack_en(ack_en), .ack_delay(ack_delay),
    .irq_req(irq_req), .irq_vector(irq_vector), .core_ack(core_ack),
    .taken_vec(taken_vec), .taken_cnt(taken_cnt)
  );

  always #10 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    miscompares++;
    $display("Error %s expected 1 seen 0", what);
    end_of_test();
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask

  task automatic ret_pulse();
    @(posedge clk);
    svc_return <= 1'b1;
    @(posedge clk);
    svc_return <= 1'b0;
  endtask

  task automatic pp(input ivp_periph_type p);
    @(posedge clk);
    periph <= p;
    @(posedge clk);
    periph <= '0;
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk);
      chk("irq_req held low", 32'h0000_0000, {31'h0, irq_req});
    end
  endtask

  task automatic wait_req();
    int n;
    n = 0;
    @(negedge clk);
    while (irq_req !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) timeout("irq_req");
  endtask

  // Waits for the core model to take one interrupt, then optionally returns
  task automatic take(input logic [15:0] v, input logic ret);
    logic [7:0] c0;
    int         n;
    c0 = taken_cnt;
    n  = 0;
    while (taken_cnt === c0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n >= 60) timeout("core_ack");
    chk("taken vector", {16'h0000, v}, {16'h0000, taken_vec});
    if (ret) ret_pulse();
  endtask

  initial begin
    clk = 1'b0; rst = 1'b1; reg_addr = 4'h0; reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0; reg_rd = 1'b0; watchdog_irq = 1'b0; ext_pin = 7'h00;
    key_port = 8'hFF; periph = '0; break_instruction = 1'b0;
    int_enable = 1'b0; svc_return = 1'b0; ack_en = 1'b0; ack_delay = 4'h0;
    miscompares = 0; check_count = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(REG_MASK, d); chk("mask", {8'h00, RST_MASK}, d);
    rd(REG_PRIO, d); chk("prio", {8'h00, RST_PRIO}, d);
    rd(REG_FLAG, d); chk("flag", 32'h0000_0000, d);
    rd(4'h7, d); chk("unmapped", 32'h0000_0000, d);
    $display("test reset values done");
    // Non-maskable with interrupts disabled, then a second one held
    @(posedge clk);
    watchdog_irq <= 1'b1;
    @(posedge clk);
    watchdog_irq <= 1'b0;
    wait_req();
    chk("nmi vector", {16'h0, VEC_NMI}, {16'h0, irq_vector});
    chk("halt release", 32'h1, {31'h0, standby_release_halt});
    ack_en <= 1'b1;
    take(16'h0004, 1'b0);
    @(posedge clk);
    watchdog_irq <= 1'b1;
    @(posedge clk);
    watchdog_irq <= 1'b0;
    quiet(6);
    ret_pulse();
    take(16'h0004, 1'b1);
    $display("test non-maskable done");
    // All maskable requests at once come out in fixed order
    wr(REG_CTRL, 32'h0000_0001);
    @(posedge clk);
    watchdog_irq <= 1'b1;
    @(posedge clk);
    watchdog_irq <= 1'b0;
    rd(REG_FLAG, d); chk("wdt flag", 32'h0000_0001, d);
    rd(REG_STAT, d); chk("wdt not nmi", 32'h0000_0000, d);
    wr(REG_MASK, 32'h0000_0000);
    wr(REG_PRIO, 32'h0000_0000);
    int_enable <= 1'b1;
    ack_delay  <= 4'h3;
    wr(REG_FLAG, 32'h00FF_FFFF);
    for (int i = 0; i < 24; i++) begin
      take(VEC_MASK_BASE + 16'(2 * i), 1'b1);
    end
    rd(REG_FLAG, d); chk("flags cleared", 32'h0000_0000, d);
    $display("test default order done");
    // High group nests over low, low waits for low
    ack_delay <= 4'h0;
    wr(REG_PRIO, 32'h0030_0000);
    wr(REG_FLAG, 32'h0010_0000);
    take(16'h002C, 1'b0);
    wr(REG_FLAG, 32'h0020_0000);
    quiet(5);
    wr(REG_FLAG, 32'h0020_0008);
    take(16'h000A, 1'b1);
    ret_pulse();
    take(16'h002E, 1'b1);
    $display("test nesting done");
    // Masked request neither offers nor wakes
    ack_en <= 1'b0;
    wr(REG_MASK, 32'h00FF_FFFF);
    pv = '0;
    pv.adc_done_irq = 1'b1;
    pp(pv);
    quiet(4);
    chk("stop release masked", 32'h0, {31'h0, standby_release_stop});
    wr(REG_MASK, 32'h00BF_FFFF);
    wait_req();
    chk("adc vector", 32'h0000_0030, {16'h0, irq_vector});
    chk("stop release", 32'h1, {31'h0, standby_release_stop});
    chk("halt release", 32'h1, {31'h0, standby_release_halt});
    ack_en <= 1'b1;
    take(16'h0030, 1'b1);
    $display("test mask done");
    // Break instruction taken while maskables are disabled
    ack_en     <= 1'b0;
    int_enable <= 1'b0;
    wr(REG_MASK, 32'h0000_0000);
    wr(REG_FLAG, 32'h0000_0200);
    quiet(4);
    @(posedge clk);
    break_instruction <= 1'b1;
    @(posedge clk);
    break_instruction <= 1'b0;
    wait_req();
    chk("break vector", {16'h0, VEC_BRK}, {16'h0, irq_vector});
    ack_en <= 1'b1;
    take(16'h003E, 1'b0);
    @(posedge clk);
    int_enable <= 1'b1;
    take(16'h0016, 1'b1);
    $display("test software done");
    // Pin edge, key return and both uses of the first timer source
    wr(REG_EDGE, 32'h0000_0004);
    @(posedge clk);
    ext_pin <= 7'h04;
    take(16'h000A, 1'b1);
    @(posedge clk);
    key_port <= 8'hDF;
    take(16'h0014, 1'b1);
    for (int m = 0; m < 2; m++) begin
      wr(REG_CTRL, 32'(1 + 2 * m));
      pv = '0;
      pv.capcmp_a_edge  = (m == 0);
      pv.capcmp_a_match = (m == 1);
      pp(pv);
      quiet(4);
      pv = ~pv & 16'h0180;
      pp(pv);
      take(16'h0024, 1'b1);
    end
    $display("test sources done");
    end_of_test();
  end
endmodule
